/* File: verilog/opcd_device.sv */
// Behaviour
// R01 - 01xxxxxx loads display start line
// R02 - 0x81 plus byte sets contrast
// R03 - 1010000x picks segment column mapping
// R04 - A4/A5 shows RAM or all on
// R05 - A6/A7 picks normal or inverted pixels
// R06 - 0xA8 plus byte sets multiplex ratio
// R07 - 0xAD plus byte gates the converter
// R08 - AE/AF switches panel off or on
// R09 - 1011xxxx loads the page address
// R10 - 1100Dxxx picks common scan direction
// R11 - 0xD3 plus byte sets display offset
// R12 - 0xD5 plus byte sets display clock
// R13 - 0xD9 plus byte sets drive periods
// R14 - 0xDA plus byte sets pad arrangement
// R15 - 0xDB plus byte sets deselect level
// R16 - E0/EE bracket read-modify-write, E3 idles
// R17 - select high is RAM, low status
`timescale 1ns/1ps
`default_nettype none
module opcd_device (
    // Clock, reset, enable
    input  wire logic       I_CLOCK,
    input  wire logic       I_RESET_N,
    input  wire logic       I_CE,
    // Link from the host
    opcd_link_if.dev_mp     LINK,
    // Display settings
    output logic [5:0]      O_START_LINE,
    output logic [7:0]      O_CONTRAST,
    output logic            O_SEG_REVERSED,
    output logic            O_ENTIRE_ON,
    output logic            O_INVERTED,
    output logic [5:0]      O_MUX_RATIO,
    output logic            O_CONVERTER_ON,
    output logic            O_PANEL_ON,
    output logic [opcd_pkg::PAGE_W-1:0] O_PAGE,
    output logic            O_SCAN_REVERSED,
    output logic [5:0]      O_OFFSET,
    output logic [7:0]      O_CLOCK_SETUP,
    output logic [7:0]      O_DRIVE_PERIODS,
    output logic            O_PADS_ALT,
    output logic [7:0]      O_COMMON_DESELECT_LEVEL,
    output logic            O_RMW_ACTIVE
);
    import opcd_pkg::*;

    typedef enum logic [1:0] {
        OPCD_ST_CMD = 2'b01,
        OPCD_ST_ARG = 2'b10
    } opcd_state_t;

    function automatic logic op_is(input logic [7:0] b, input logic [7:0] op, input logic [7:0] msk);
        op_is = (b & msk) == op;
    endfunction

    function automatic logic two_byte(input logic [7:0] b);
        case (b)
            OP_CONTRAST, OP_MUX, OP_CONV, OP_OFFSET,
            OP_CLKDIV, OP_PRECHG, OP_PADS, OP_DESEL: two_byte = 1'b1;
            default: two_byte = 1'b0;
        endcase
    endfunction

    // ======================================================
    // Link acceptance
    opcd_state_t        state_ff;
    logic [7:0]         pend_ff;
    logic               ack_ff;
    logic [7:0]         rdata_ff;
    logic [7:0]         ram [0:RAM_DEPTH-1];
    logic [COL_W-1:0]   col_ff;
    logic [COL_W-1:0]   col_save_ff;
    logic [PAGE_W-1:0]  page_ff;
    logic               rmw_ff;
    logic               panel_on_ff;
    logic [9:0]         addr;
    logic [7:0]         b;
    logic               take;
    logic               cmd1;
    logic               arg;
    logic               ram_wr;
    logic               ram_rd;

    // One take per request; the cycle after a take is blocked by ack
    assign take   = I_CE && LINK.req && !ack_ff;
    assign b      = LINK.wdata;
    assign cmd1   = take && LINK.wr && !LINK.dcs && state_ff == OPCD_ST_CMD;
    assign arg    = take && LINK.wr && !LINK.dcs && state_ff == OPCD_ST_ARG;
    assign ram_wr = take && LINK.wr && LINK.dcs;
    assign ram_rd = take && !LINK.wr && LINK.dcs;
    assign addr   = {page_ff, col_ff};

    assign LINK.ack   = ack_ff;
    assign LINK.rdata = rdata_ff;

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ack_ff <= 1'b0;
        end else if (I_CE) begin
            ack_ff <= take;
        end
    end

    // Two-byte commands wait here for their argument
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_ff <= OPCD_ST_CMD;
            pend_ff  <= 8'h00;
        end else if (I_CE) begin
            case (state_ff)
                OPCD_ST_CMD: begin
                    if (cmd1 && two_byte(b)) begin
                        state_ff <= OPCD_ST_ARG;
                        pend_ff  <= b;
                    end
                end
                OPCD_ST_ARG: begin
                    if (arg) begin
                        state_ff <= OPCD_ST_CMD;
                    end
                end
                default: state_ff <= OPCD_ST_CMD;
            endcase
        end
    end

    // ======================================================
    // Single-byte settings
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_START_LINE    <= RST_START[5:0];
            O_SEG_REVERSED  <= RST_SEG[0];
            O_ENTIRE_ON     <= RST_ENTIRE[0];
            O_INVERTED      <= RST_INV[0];
            panel_on_ff     <= RST_PANEL[0];
            page_ff         <= RST_PAGE[PAGE_W-1:0];
            O_SCAN_REVERSED <= RST_SCAN[3];
        end else if (cmd1) begin
            // R01 - start line load
            if (op_is(b, OP_START, MSK_START)) begin
                O_START_LINE <= b[5:0];
            end
            // R03 - segment remap
            if (op_is(b, OP_SEG, MSK_BIT0)) begin
                O_SEG_REVERSED <= b[0];
            end
            // R04 - entire display on
            if (op_is(b, OP_ENTIRE, MSK_BIT0)) begin
                O_ENTIRE_ON <= b[0];
            end
            // R05 - pixel polarity
            if (op_is(b, OP_INV, MSK_BIT0)) begin
                O_INVERTED <= b[0];
            end
            // R08 - panel on or off
            if (op_is(b, OP_PANEL, MSK_BIT0)) begin
                panel_on_ff <= b[0];
            end
            // R09 - page address, upper page bit ignored on 8 pages
            if (op_is(b, OP_PAGE, MSK_PAGE)) begin
                page_ff <= b[PAGE_W-1:0];
            end
            // R10 - scan direction, low bits ignored
            if (op_is(b, OP_SCAN, MSK_SCAN)) begin
                O_SCAN_REVERSED <= b[3];
            end
        end
    end

    assign O_PANEL_ON = panel_on_ff;
    assign O_PAGE     = page_ff;

    // ======================================================
    // Argument bytes of two-byte commands
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CONTRAST              <= RST_CONTRAST;
            O_MUX_RATIO             <= RST_MUX[5:0];
            O_CONVERTER_ON          <= RST_CONV[0];
            O_OFFSET                <= RST_OFFSET[5:0];
            O_CLOCK_SETUP           <= RST_CLKDIV;
            O_DRIVE_PERIODS         <= RST_PRECHG;
            O_PADS_ALT              <= RST_PADS[PADS_ALT_BIT];
            O_COMMON_DESELECT_LEVEL <= RST_DESEL;
        end else if (arg) begin
            case (pend_ff)
                // R02 - all 256 contrast levels
                OP_CONTRAST: O_CONTRAST <= b;
                // R06 - top two bits dropped
                OP_MUX: O_MUX_RATIO <= b[5:0];
                // R07 - converter gate bit
                OP_CONV: O_CONVERTER_ON <= b[0];
                // R11 - offset low six bits
                OP_OFFSET: O_OFFSET <= b[5:0];
                // R12 - divide and oscillator fields
                OP_CLKDIV: O_CLOCK_SETUP <= b;
                // R13 - discharge high, pre-charge low
                OP_PRECHG: O_DRIVE_PERIODS <= b;
                // R14 - pad arrangement bit
                OP_PADS: O_PADS_ALT <= b[PADS_ALT_BIT];
                // R15 - deselect level byte
                OP_DESEL: O_COMMON_DESELECT_LEVEL <= b;
                default: O_CONTRAST <= O_CONTRAST;
            endcase
        end
    end

    // ======================================================
    // Column pointer and read-modify-write
    // R16 - reads leave the column alone inside the bracket
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            col_ff      <= '0;
            col_save_ff <= '0;
            rmw_ff      <= 1'b0;
        end else if (cmd1 && b == OP_RMW_GO) begin
            rmw_ff      <= 1'b1;
            col_save_ff <= col_ff;
        end else if (cmd1 && b == OP_RMW_END) begin
            rmw_ff <= 1'b0;
            col_ff <= col_save_ff;
        end else if (ram_wr || (ram_rd && !rmw_ff)) begin
            col_ff <= (col_ff == COL_LAST) ? '0 : col_ff + 1'b1;
        end
    end

    assign O_RMW_ACTIVE = rmw_ff;

    // ======================================================
    // Display RAM and read answers
    // R17 - data write stores into RAM
    always_ff @(posedge I_CLOCK) begin
        if (ram_wr) begin
            ram[addr] <= b;
        end
    end

    // R17 - status or RAM on reads
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_ff <= 8'h00;
        end else if (take && !LINK.wr) begin
            if (LINK.dcs) begin
                rdata_ff <= ram[addr];
            end else begin
                // Every access completes in one cycle, so busy never shows
                rdata_ff <= 8'h00;
                rdata_ff[STAT_OFF_BIT] <= !panel_on_ff;
            end
        end
    end
endmodule
`default_nettype wire

/* File: include/opcd_pkg.sv */
`default_nettype none
package opcd_pkg;
    // ======================================================
    // Link widths and display RAM geometry
    localparam int BYTE_W = 8;
    localparam int COL_W  = 7;
    localparam int PAGE_W = 3;
    localparam int RAM_DEPTH = 1024;
    localparam logic [COL_W-1:0] COL_LAST = 7'h7F;
    // ======================================================
    // Single-byte opcodes, compared under a mask except E0 and EE (exact) and E3 (unused)
    localparam logic [7:0] OP_START  = 8'h40;
    localparam logic [7:0] MSK_START = 8'hC0;
    localparam logic [7:0] OP_SEG    = 8'hA0;
    localparam logic [7:0] OP_ENTIRE = 8'hA4;
    localparam logic [7:0] OP_INV    = 8'hA6;
    localparam logic [7:0] OP_PANEL  = 8'hAE;
    localparam logic [7:0] MSK_BIT0  = 8'hFE;
    localparam logic [7:0] OP_PAGE   = 8'hB0;
    localparam logic [7:0] MSK_PAGE  = 8'hF0;
    localparam logic [7:0] OP_SCAN   = 8'hC0;
    localparam logic [7:0] MSK_SCAN  = 8'hF0;
    localparam logic [7:0] OP_RMW_GO = 8'hE0;
    localparam logic [7:0] OP_RMW_END = 8'hEE;
    localparam logic [7:0] OP_NOP    = 8'hE3;
    // Two-byte opcodes
    localparam logic [7:0] OP_CONTRAST = 8'h81;
    localparam logic [7:0] OP_MUX      = 8'hA8;
    localparam logic [7:0] OP_CONV     = 8'hAD;
    localparam logic [7:0] OP_OFFSET   = 8'hD3;
    localparam logic [7:0] OP_CLKDIV   = 8'hD5;
    localparam logic [7:0] OP_PRECHG   = 8'hD9;
    localparam logic [7:0] OP_PADS     = 8'hDA;
    localparam logic [7:0] OP_DESEL    = 8'hDB;
    // ======================================================
    // Values after reset
    localparam logic [7:0] RST_START    = 8'h40;
    localparam logic [7:0] RST_CONTRAST = 8'h80;
    localparam logic [7:0] RST_SEG      = 8'hA0;
    localparam logic [7:0] RST_ENTIRE   = 8'hA4;
    localparam logic [7:0] RST_INV      = 8'hA6;
    localparam logic [7:0] RST_MUX      = 8'h3F;
    localparam logic [7:0] RST_CONV     = 8'h8B;
    localparam logic [7:0] RST_PANEL    = 8'hAE;
    localparam logic [7:0] RST_PAGE     = 8'hB0;
    localparam logic [7:0] RST_SCAN     = 8'hC0;
    localparam logic [7:0] RST_OFFSET   = 8'h00;
    localparam logic [7:0] RST_CLKDIV   = 8'h50;
    localparam logic [7:0] RST_PRECHG   = 8'h22;
    localparam logic [7:0] RST_PADS     = 8'h12;
    localparam logic [7:0] RST_DESEL    = 8'h35;
    // Status byte fields and the pad arrangement bit
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_OFF_BIT  = 6;
    localparam int PADS_ALT_BIT  = 4;
    // ======================================================
    // Controller register map (APB, byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RDATA  = 8'h08;
    localparam int CTRL_DCS_BIT  = 8;
    localparam int CTRL_READ_BIT = 9;
    localparam int STS_BUSY_BIT  = 0;
    localparam int STS_DONE_BIT  = 1;
endpackage
`default_nettype wire

/* File: include/opcd_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface opcd_link_if;
    logic       req;
    logic       wr;
    logic       dcs;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    modport dev_mp  (input req, wr, dcs, wdata, output ack, rdata);
    modport host_mp (output req, wr, dcs, wdata, input ack, rdata);
endinterface
`default_nettype wire

/* File: verilog/opcd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module opcd_host (
    // Clock, reset, enable
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESET_N,
    input  wire logic        I_CE,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Link to the panel decoder
    opcd_link_if.host_mp     LINK
);
    import opcd_pkg::*;

    // ======================================================
    // Bus decode
    logic        busy_ff;
    logic        done_ff;
    logic [7:0]  rbyte_ff;
    logic [31:0] prdata_ff;
    logic        perr_ff;
    logic        setup;
    logic        wr_ctrl;
    logic        start;
    logic        mapped;

    assign setup   = I_PSEL && !I_PENABLE;
    assign wr_ctrl = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == REG_CTRL;
    // Refused while a link transfer is still open
    assign start   = wr_ctrl && !busy_ff;
    assign mapped  = I_PADDR == REG_CTRL || I_PADDR == REG_STATUS || I_PADDR == REG_RDATA;

    assign O_PREADY  = 1'b1;
    assign O_PRDATA  = prdata_ff;
    assign O_PSLVERR = perr_ff;

    // Read data prepared in the setup cycle so it comes from a flop
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            prdata_ff <= 32'h0000_0000;
            perr_ff   <= 1'b0;
        end else if (I_CE && setup) begin
            perr_ff <= !mapped;
            case (I_PADDR)
                REG_STATUS: prdata_ff <= {30'h0000_0000, done_ff, busy_ff};
                REG_RDATA:  prdata_ff <= {24'h00_0000, rbyte_ff};
                default:    prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================
    // Link transfer
    // R02 - host sends opcode then its data byte
    // R17 - select high for RAM, low for commands
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            LINK.req   <= 1'b0;
            LINK.wr    <= 1'b0;
            LINK.dcs   <= 1'b0;
            LINK.wdata <= 8'h00;
        end else if (I_CE) begin
            if (start) begin
                LINK.req   <= 1'b1;
                LINK.wr    <= !I_PWDATA[CTRL_READ_BIT];
                LINK.dcs   <= I_PWDATA[CTRL_DCS_BIT];
                LINK.wdata <= I_PWDATA[7:0];
            end else if (LINK.ack) begin
                LINK.req <= 1'b0;
            end
        end
    end

    // R06 - argument bytes written exactly as given
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
            rbyte_ff <= 8'h00;
        end else if (I_CE) begin
            if (start) begin
                busy_ff <= 1'b1;
                done_ff <= 1'b0;
            end else if (busy_ff && LINK.ack) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
                if (!LINK.wr) begin
                    rbyte_ff <= LINK.rdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/opcd_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module opcd_link_props (
    // Clock, reset, enable
    input wire logic       I_CLOCK,
    input wire logic       I_RESET_N,
    input wire logic       I_CE,
    // Link signals
    input wire logic       req,
    input wire logic       wr,
    input wire logic       dcs,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    // ======================================================
    // Handshake steps
    sequence s_take; req && !ack && I_CE; endsequence
    sequence s_pulse; ack ##1 !ack; endsequence
    property p_answer; s_take |=> s_pulse; endproperty
    property p_cause; ack |-> $past(req) && !$past(ack); endproperty
    property p_release; ack |=> !req; endproperty
    property p_hold; req && !ack |=> req && $stable(wdata) && $stable(wr) && $stable(dcs); endproperty
    property p_gap; $fell(req) |-> !ack; endproperty
    // Status byte has fixed zero fields, device never busy
    property p_status; ack && !wr && !dcs |-> rdata[7] == 1'b0 && rdata[2:0] == 3'h0; endproperty
    property p_kept; $changed(rdata) |-> ack && !wr; endproperty
    property p_wrkeep; ack && wr |-> $stable(rdata); endproperty
    a_answer: assert property (p_answer) else $error("ack is not one pulse after take");
    a_cause: assert property (p_cause) else $error("ack without a pending request");
    a_release: assert property (p_release) else $error("req held after ack");
    a_hold: assert property (p_hold) else $error("request changed before ack");
    a_gap: assert property (p_gap) else $error("ack still high after req fell");
    a_status: assert property (p_status) else $error("status byte fixed bits wrong");
    a_kept: assert property (p_kept) else $error("read byte changed outside a read");
    a_wrkeep: assert property (p_wrkeep) else $error("write disturbed read byte");
endmodule
`default_nettype wire

/* File: tb/oled_panel_command_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module oled_panel_command_decoder_test;
    import opcd_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [5:0]        start_line, mux_ratio, offset;
    logic [7:0]        contrast, clock_setup, periods, desel;
    logic              seg_rev, entire_on, inverted, conv_on, panel_on, scan_rev, pads_alt, rmw;
    logic [PAGE_W-1:0] page;
    int                error_cnt = 0;
    int                total_checks = 0;
    opcd_link_if link ();
    opcd_host u_opcd_host (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(link));
    opcd_device u_opcd_device (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CE(ce), .LINK(link),
        .O_START_LINE(start_line), .O_CONTRAST(contrast), .O_SEG_REVERSED(seg_rev),
        .O_ENTIRE_ON(entire_on), .O_INVERTED(inverted), .O_MUX_RATIO(mux_ratio),
        .O_CONVERTER_ON(conv_on), .O_PANEL_ON(panel_on), .O_PAGE(page), .O_SCAN_REVERSED(scan_rev),
        .O_OFFSET(offset), .O_CLOCK_SETUP(clock_setup), .O_DRIVE_PERIODS(periods),
        .O_PADS_ALT(pads_alt), .O_COMMON_DESELECT_LEVEL(desel), .O_RMW_ACTIVE(rmw));
    opcd_link_props u_opcd_link_props (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_CE(ce),
        .req(link.req), .wr(link.wr), .dcs(link.dcs), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata));
    always #50 clk = ~clk;
    // ======================================================
    // Bus tasks
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Waits on pready without a count; the watchdog cuts a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task xfer(input logic rdb, input logic dc, input logic [7:0] b);
        int n;
        apb(1'b1, REG_CTRL, {22'h0, rdb, dc, b});
        n = 0;
        rd = 32'h0;
        while (rd[STS_DONE_BIT] !== 1'b1 && n < 20) begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        chk("link done", 32'h1, {31'h0, rd[STS_DONE_BIT]});
        if (rdb) apb(1'b0, REG_RDATA, 32'h0);
    endtask
    task cmd(input logic [7:0] b);
        xfer(1'b0, 1'b0, b);
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    // ======================================================
    // Tests
    initial begin
        rst_n <= 1'b0;
        ce <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk("start", 32'h0, start_line);
        chk("contrast", 32'h80, contrast);
        chk("seg", 32'h0, seg_rev);
        chk("entire", 32'h0, entire_on);
        chk("inverse", 32'h0, inverted);
        chk("mux", 32'h3F, mux_ratio);
        chk("conv", 32'h1, conv_on);
        chk("panel", 32'h0, panel_on);
        chk("page", 32'h0, page);
        chk("scan", 32'h0, scan_rev);
        chk("offset", 32'h0, offset);
        chk("clock", 32'h50, clock_setup);
        chk("periods", 32'h22, periods);
        chk("pads", 32'h1, pads_alt);
        chk("deselect", 32'h35, desel);
        chk("rmw", 32'h0, rmw);
        xfer(1'b1, 1'b0, 8'h00);
        chk("status off", 32'h40, {24'h0, rd[7:0]});
        cmd(8'h7F);
        chk("start", 32'h3F, start_line);
        cmd(OP_CONTRAST);
        cmd(8'hFF);
        chk("contrast", 32'hFF, contrast);
        // Display write between opcode and argument
        cmd(OP_CONTRAST);
        xfer(1'b0, 1'b1, 8'h5A);
        cmd(8'h00);
        chk("contrast", 32'h0, contrast);
        cmd(8'hA1);
        chk("seg", 32'h1, seg_rev);
        cmd(8'hA5);
        chk("entire", 32'h1, entire_on);
        cmd(8'hA7);
        chk("inverse", 32'h1, inverted);
        // Enable low: a control write must not reach the panel
        ce <= 1'b0;
        apb(1'b1, REG_CTRL, {22'h0, 2'b00, 8'hA6});
        repeat (4) @(posedge clk);
        chk("frozen", 32'h1, inverted);
        ce <= 1'b1;
        cmd(OP_MUX);
        cmd(8'hC5);
        chk("mux", 32'h05, mux_ratio);
        cmd(OP_CONV);
        cmd(8'h8A);
        chk("conv", 32'h0, conv_on);
        cmd(8'hAF);
        chk("panel", 32'h1, panel_on);
        xfer(1'b1, 1'b0, 8'h00);
        chk("status on", 32'h00, {24'h0, rd[7:0]});
        // Argument that looks like panel off
        cmd(OP_CONTRAST);
        cmd(8'hAE);
        chk("contrast", 32'hAE, contrast);
        chk("panel", 32'h1, panel_on);
        cmd(8'hBD);
        chk("page", 32'h5, page);
        cmd(8'hC8);
        chk("scan", 32'h1, scan_rev);
        cmd(8'hC7);
        chk("scan", 32'h0, scan_rev);
        cmd(OP_OFFSET);
        cmd(8'hE7);
        chk("offset", 32'h27, offset);
        cmd(OP_CLKDIV);
        cmd(8'hF1);
        chk("clock", 32'hF1, clock_setup);
        cmd(OP_PRECHG);
        cmd(8'hA3);
        chk("periods", 32'hA3, periods);
        cmd(OP_PADS);
        cmd(8'h02);
        chk("pads", 32'h0, pads_alt);
        cmd(OP_DESEL);
        cmd(8'h1C);
        chk("deselect", 32'h1C, desel);
        cmd(OP_NOP);
        chk("nop", 32'h1C, desel);
        chk("nop", 32'hAE, contrast);
        // Column comes back to the bracket start
        cmd(OP_RMW_GO);
        chk("rmw", 32'h1, rmw);
        xfer(1'b0, 1'b1, 8'hA5);
        xfer(1'b0, 1'b1, 8'hC3);
        cmd(OP_RMW_END);
        chk("rmw", 32'h0, rmw);
        xfer(1'b1, 1'b1, 8'h00);
        chk("ram", 32'hA5, {24'h0, rd[7:0]});
        xfer(1'b1, 1'b1, 8'h00);
        chk("ram", 32'hC3, {24'h0, rd[7:0]});
        // Reads inside a bracket keep the column
        cmd(OP_RMW_GO);
        xfer(1'b0, 1'b1, 8'h96);
        cmd(OP_RMW_END);
        cmd(OP_RMW_GO);
        xfer(1'b1, 1'b1, 8'h00);
        xfer(1'b1, 1'b1, 8'h00);
        chk("rmw read", 32'h96, {24'h0, rd[7:0]});
        cmd(OP_RMW_END);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        chk("ready", 32'h1, {31'h0, pready});
        final_report();
    end
endmodule
`default_nettype wire
